// ==== shared/tlbr_defines.svh ====
// Constants for the TLB lockdown and process remap block
`ifndef TLBR_DEFINES_SVH
`define TLBR_DEFINES_SVH
`define TLBR_CRN_TLBOP 4'h8
`define TLBR_CRN_LOCK 4'hA
`define TLBR_CRN_PID 4'hD
`define TLBR_OP2_D 3'h0
`define TLBR_OP2_I 3'h1
`define TLBR_OP2_ALL 3'h0
`define TLBR_OP2_ONE 3'h1
`define TLBR_CRM_BOTH 4'h7
`define TLBR_CRM_I 4'h5
`define TLBR_CRM_D 4'h6
`define TLBR_LOCK_BASE_HI 31
`define TLBR_LOCK_BASE_LO 26
`define TLBR_LOCK_VICT_HI 25
`define TLBR_LOCK_VICT_LO 20
`define TLBR_LOCK_PRES_BIT 0
`define TLBR_PID_HI 31
`define TLBR_PID_LO 25
`define TLBR_PID_RST 7'h00
`define TLBR_VICT_TOP 6'h3F
`define TLBR_PID_LAG 2'h2
`define TLBR_FLAT_TOP 7'h00
`define TLBR_ENTRIES 64
`endif

// ==== shared/tlbr_pkg.sv ====
// Types for the TLB lockdown and process remap block
package tlbr_pkg;
  typedef enum logic [1:0] {
    SZ_SECT = 2'b00, SZ_LARGE = 2'b01, SZ_SMALL = 2'b10, SZ_TINY = 2'b11
  } tlbr_size_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_LOOK = 2'b01, ST_WALK = 2'b10
  } tlbr_state_t;
  typedef struct packed {
    logic [5:0] base;
    logic [5:0] victim;
    logic pres;
  } tlbr_lock_t;
  typedef struct packed {
    tlbr_size_t size;
    logic [3:0] dom;
    logic [7:0] ap;
    logic c;
    logic b;
    logic [21:0] pa;
  } tlbr_walk_t;
  typedef struct packed {
    logic valid;
    logic pres;
    logic [21:0] va;
    tlbr_walk_t w;
  } tlbr_ent_t;
endpackage

// ==== rtl/tlbr_top.sv ====
// TLB lockdown, victim selection, lookup and process-ID address remap
`timescale 1ns/1ps
`include "tlbr_defines.svh"
module tlbr_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  input wire logic [31:0] cp_wdata,
  output logic [31:0] cp_rdata,
  input wire logic mmu_enable,
  input wire logic [31:0] dacr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic req_priv,
  output logic resp_valid,
  output logic [31:0] resp_pa,
  output logic resp_abort,
  output logic resp_cache,
  output logic resp_buf,
  output logic walk_req,
  output logic [31:0] walk_mva,
  input wire logic walk_done,
  input wire tlbr_pkg::tlbr_walk_t walk_data
);
  tlbr_pkg::tlbr_ent_t mem_r [2][`TLBR_ENTRIES];
  tlbr_pkg::tlbr_lock_t lock_r [2];
  tlbr_pkg::tlbr_lock_t lock_nxt [2];
  tlbr_pkg::tlbr_state_t st_r, st_nxt;
  tlbr_pkg::tlbr_ent_t hit_e;
  logic [6:0] pid_r, pid_nxt, pid_old_r, pid_old_nxt, fpid;
  logic [1:0] lag_r, lag_nxt;
  logic [31:0] mva_r, mva_nxt, rdata_r, rdata_nxt, pa_r, pa_nxt;
  logic side_r, side_nxt, wr_r, wr_nxt, priv_r, priv_nxt;
  logic rv_r, rv_nxt, ab_r, ab_nxt, ca_r, ca_nxt, bu_r, bu_nxt;
  logic hit, fill, cp_rd, cp_wr, take, ok;
  logic [5:0] hit_idx;
  logic [1:0] dmode, inv_all, inv_one;
  // Index 0 is the data TLB, 1 the instruction TLB
  function automatic logic [21:0] size_mask(tlbr_pkg::tlbr_size_t s);
    case (s)
      tlbr_pkg::SZ_SECT: return 22'h3FFC00;
      tlbr_pkg::SZ_LARGE: return 22'h3FFFC0;
      tlbr_pkg::SZ_SMALL: return 22'h3FFFFC;
      default: return 22'h3FFFFF;
    endcase
  endfunction
  // Tag compare at the entry's own page size
  function automatic logic ent_hit(tlbr_pkg::tlbr_ent_t e, logic [31:0] a);
    return e.valid && (((e.va ^ a[31:10]) & size_mask(e.w.size)) == 22'h000000);
  endfunction
  // Quarter subpage picks its own permission pair
  function automatic logic [1:0] sub_ap(tlbr_pkg::tlbr_ent_t e, logic [31:0] a);
    case (e.w.size)
      tlbr_pkg::SZ_LARGE: return e.w.ap[{a[15:14], 1'b0} +: 2];
      tlbr_pkg::SZ_SMALL: return e.w.ap[{a[11:10], 1'b0} +: 2];
      default: return e.w.ap[1:0];
    endcase
  endfunction
  // System and ROM protect bits are outside this block; 00 always denies
  function automatic logic perm_ok(logic [1:0] ap, logic priv, logic wr);
    case (ap)
      2'h1: return priv;
      2'h2: return priv | ~wr;
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // Low 32MB slot is moved up by identifier times 32MB
  function automatic logic [31:0] remap(logic [31:0] a, logic [6:0] pid);
    if (a[31:25] == `TLBR_FLAT_TOP) return {pid, a[24:0]};
    return a;
  endfunction
  // Coprocessor decode; reserved numbers fall through untouched
  always_comb begin
    cp_rd = cp_valid & ~cp_write;
    cp_wr = cp_valid & cp_write;
    inv_all = 2'b00;
    inv_one = 2'b00;
    if (cp_wr && cp_crn == `TLBR_CRN_TLBOP) begin
      if (cp_op2 == `TLBR_OP2_ALL) begin
        if (cp_crm == `TLBR_CRM_BOTH) inv_all = 2'b11;
        if (cp_crm == `TLBR_CRM_D) inv_all = 2'b01;
        if (cp_crm == `TLBR_CRM_I) inv_all = 2'b10;
      end
      if (cp_op2 == `TLBR_OP2_ONE) begin
        if (cp_crm == `TLBR_CRM_D) inv_one = 2'b01;
        if (cp_crm == `TLBR_CRM_I) inv_one = 2'b10;
      end
    end
  end
  // Priority search over the selected TLB; first match wins
  always_comb begin
    hit = 1'b0;
    hit_idx = 6'h00;
    for (int i = 0; i < `TLBR_ENTRIES; i++) begin
      if (!hit && ent_hit(mem_r[side_r][i], mva_r)) begin
        hit = 1'b1;
        hit_idx = 6'(i);
      end
    end
    hit_e = mem_r[side_r][hit_idx];
    dmode = dacr[{hit_e.w.dom, 1'b0} +: 2];
    case (dmode)
      2'h1: ok = perm_ok(sub_ap(hit_e, mva_r), priv_r, wr_r);
      2'h3: ok = 1'b1;
      default: ok = 1'b0;
    endcase
  end
  assign fill = (st_r == tlbr_pkg::ST_WALK) & walk_done;
  assign take = req_valid & req_ready;
  assign fpid = (lag_r != 2'h0) ? pid_old_r : pid_r;
  // Control next state: sequencer, lockdown, identifier, answers
  always_comb begin
    st_nxt = st_r;
    lock_nxt = lock_r;
    pid_nxt = pid_r;
    pid_old_nxt = pid_old_r;
    lag_nxt = lag_r;
    mva_nxt = mva_r;
    side_nxt = side_r;
    wr_nxt = wr_r;
    priv_nxt = priv_r;
    rdata_nxt = rdata_r;
    rv_nxt = 1'b0;
    ab_nxt = ab_r;
    ca_nxt = ca_r;
    bu_nxt = bu_r;
    pa_nxt = pa_r;
    req_ready = (st_r == tlbr_pkg::ST_IDLE);
    case (st_r)
      tlbr_pkg::ST_IDLE: begin
        if (req_valid) begin
          // Fetches lag the identifier so the pipeline's queued fetches match
          mva_nxt = remap(req_addr, req_fetch ? fpid : pid_r);
          side_nxt = req_fetch;
          wr_nxt = req_write;
          priv_nxt = req_priv;
          if (req_fetch && lag_r != 2'h0) lag_nxt = lag_r - 2'h1;
          st_nxt = tlbr_pkg::ST_LOOK;
        end
      end
      tlbr_pkg::ST_LOOK: begin
        if (!mmu_enable) begin
          rv_nxt = 1'b1;
          pa_nxt = mva_r;
          ab_nxt = 1'b0;
          ca_nxt = 1'b0;
          bu_nxt = 1'b0;
          st_nxt = tlbr_pkg::ST_IDLE;
        end else if (hit) begin
          rv_nxt = 1'b1;
          ab_nxt = ~ok;
          ca_nxt = ok & hit_e.w.c;
          bu_nxt = ok & hit_e.w.b;
          pa_nxt = ok ? {(hit_e.w.pa & size_mask(hit_e.w.size))
                       | (mva_r[31:10] & ~size_mask(hit_e.w.size)), mva_r[9:0]} : 32'h00000000;
          st_nxt = tlbr_pkg::ST_IDLE;
        end else begin
          st_nxt = tlbr_pkg::ST_WALK;
        end
      end
      tlbr_pkg::ST_WALK: begin
        if (walk_done) st_nxt = tlbr_pkg::ST_LOOK;
      end
      default: st_nxt = tlbr_pkg::ST_IDLE;
    endcase
    if (fill) begin
      // Round robin inside the unlocked range only
      lock_nxt[side_r].victim = (lock_r[side_r].victim == `TLBR_VICT_TOP)
                                ? lock_r[side_r].base
                                : lock_r[side_r].victim + 6'h01;
    end
    if (cp_wr && cp_crn == `TLBR_CRN_LOCK) begin
      // A write lands after any fill advance in the same cycle
      lock_nxt[cp_op2[0]].base = cp_wdata[`TLBR_LOCK_BASE_HI:`TLBR_LOCK_BASE_LO];
      lock_nxt[cp_op2[0]].victim = cp_wdata[`TLBR_LOCK_VICT_HI:`TLBR_LOCK_VICT_LO];
      lock_nxt[cp_op2[0]].pres = cp_wdata[`TLBR_LOCK_PRES_BIT];
    end
    if (cp_wr && cp_crn == `TLBR_CRN_PID) begin
      pid_old_nxt = pid_r;
      pid_nxt = cp_wdata[`TLBR_PID_HI:`TLBR_PID_LO];
      lag_nxt = `TLBR_PID_LAG;
    end
    if (cp_rd) begin
      // Unused bits read as zero; reserved registers answer zero
      case (cp_crn)
        `TLBR_CRN_LOCK: rdata_nxt = {lock_r[cp_op2[0]].base, lock_r[cp_op2[0]].victim,
                                     19'h00000, lock_r[cp_op2[0]].pres};
        `TLBR_CRN_PID: rdata_nxt = {pid_r, 25'h0000000};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end
  // Control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= tlbr_pkg::ST_IDLE;
      lock_r[0] <= '0;
      lock_r[1] <= '0;
      pid_r <= `TLBR_PID_RST;
      pid_old_r <= `TLBR_PID_RST;
      lag_r <= 2'h0;
      mva_r <= 32'h00000000;
      side_r <= 1'b0;
      wr_r <= 1'b0;
      priv_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rv_r <= 1'b0;
      ab_r <= 1'b0;
      ca_r <= 1'b0;
      bu_r <= 1'b0;
      pa_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      lock_r <= lock_nxt;
      pid_r <= pid_nxt;
      pid_old_r <= pid_old_nxt;
      lag_r <= lag_nxt;
      mva_r <= mva_nxt;
      side_r <= side_nxt;
      wr_r <= wr_nxt;
      priv_r <= priv_nxt;
      rdata_r <= rdata_nxt;
      rv_r <= rv_nxt;
      ab_r <= ab_nxt;
      ca_r <= ca_nxt;
      bu_r <= bu_nxt;
      pa_r <= pa_nxt;
    end
  end
  // Entry store; a fill is applied after invalidation so it survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < 2; t++)
        for (int i = 0; i < `TLBR_ENTRIES; i++) mem_r[t][i] <= '0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        for (int i = 0; i < `TLBR_ENTRIES; i++) begin
          if (inv_all[t] && !mem_r[t][i].pres) mem_r[t][i].valid <= 1'b0;
          if (inv_one[t] && ent_hit(mem_r[t][i], cp_wdata)) mem_r[t][i].valid <= 1'b0;
          if (fill && side_r == t[0] && lock_r[t].victim == 6'(i)) begin
            mem_r[t][i].valid <= 1'b1;
            mem_r[t][i].pres <= lock_r[t].pres;
            mem_r[t][i].va <= mva_r[31:10];
            mem_r[t][i].w <= walk_data;
          end
        end
      end
    end
  end
  assign cp_rdata = rdata_r;
  assign resp_valid = rv_r;
  assign resp_pa = pa_r;
  assign resp_abort = ab_r;
  assign resp_cache = ca_r;
  assign resp_buf = bu_r;
  assign walk_req = (st_r == tlbr_pkg::ST_WALK);
  assign walk_mva = mva_r;
  // Checks
  logic unpres_d;
  always_comb begin
    unpres_d = 1'b0;
    for (int i = 0; i < `TLBR_ENTRIES; i++)
      unpres_d = unpres_d | (mem_r[0][i].valid & ~mem_r[0][i].pres);
  end
  sequence s_pid_wr;
    cp_wr && cp_crn == `TLBR_CRN_PID;
  endsequence
  sequence s_low_take;
    take && !req_fetch && req_addr[31:25] == 7'h00;
  endsequence

  a_lock_reset_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> lock_r[0] == '0 && lock_r[1] == '0 && pid_r == 7'h00)
    else $error("lock or identifier not zero after reset");
  a_victim_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    fill && !cp_wr && lock_r[side_r].victim == 6'h3F |=> lock_r[$past(side_r)].victim
      == $past(lock_r[side_r].base))
    else $error("victim did not wrap to base");
  a_victim_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !fill && !cp_wr |=> $stable(lock_r[0].victim) && $stable(lock_r[1].victim))
    else $error("victim moved without a fill");
  a_pres_mark: assert property (@(posedge sys_clk) disable iff (rst)
    fill |=> mem_r[$past(side_r)][$past(lock_r[side_r].victim)].pres
      == $past(lock_r[side_r].pres))
    else $error("preserve mark not taken from lockdown");
  a_inv_all_d: assert property (@(posedge sys_clk) disable iff (rst)
    inv_all[0] && !(fill && !side_r) |=> !unpres_d)
    else $error("unpreserved data entry survived invalidate-all");
  a_remap_low: assert property (@(posedge sys_clk) disable iff (rst)
    s_low_take |=> mva_r == {$past(pid_r), $past(req_addr[24:0])})
    else $error("low address not remapped");
  a_remap_high: assert property (@(posedge sys_clk) disable iff (rst)
    take && req_addr[31:25] != 7'h00 |=> mva_r == $past(req_addr))
    else $error("high address altered");
  a_pid_lag: assert property (@(posedge sys_clk) disable iff (rst)
    s_pid_wr |=> lag_r == 2'h2 && pid_old_r == $past(pid_r))
    else $error("identifier lag not armed with old value");
  a_mmu_off: assert property (@(posedge sys_clk) disable iff (rst)
    st_r == tlbr_pkg::ST_LOOK && !mmu_enable |=> resp_valid && resp_pa == $past(mva_r)
      && !resp_cache && !resp_buf && !resp_abort)
    else $error("translation off answer wrong");
endmodule // tlbr_top

// ==== tb/tlbr_walker.sv ====
// Table-walk partner model that answers the block's walk requests
`timescale 1ns/1ps
module tlbr_walker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic walk_req,
  input wire logic [3:0] lat,
  input wire tlbr_pkg::tlbr_walk_t tmpl,
  output logic walk_done,
  output tlbr_pkg::tlbr_walk_t walk_data
);
  logic [3:0] cnt_r;
  // Answer lat+1 cycles after the request rises; outside the answer the data toggles so stale values never pass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      walk_done <= 1'b0;
      walk_data <= '0;
    end else if (walk_req && !walk_done) begin
      if (cnt_r == lat) begin
        walk_done <= 1'b1; // Walker always fills
        walk_data <= tmpl;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
        walk_data <= tlbr_pkg::tlbr_walk_t'(~walk_data);
      end
    end else begin
      walk_done <= 1'b0;
      walk_data <= tlbr_pkg::tlbr_walk_t'(~walk_data);
    end
  end
endmodule // tlbr_walker

// ==== tb/tlbr_top_tb.sv ====
// Self-checking bench for the TLB lockdown and process remap block
`timescale 1ns/1ps
module tlbr_top_tb;
  logic sys_clk, rst, cp_valid, cp_write, mmu_enable, req_valid, req_fetch, req_write, req_priv;
  logic [3:0] cp_crn, cp_crm, lat;
  logic [2:0] cp_op2;
  logic [31:0] cp_wdata, cp_rdata, dacr, req_addr, resp_pa, walk_mva, a;
  logic req_ready, resp_valid, resp_abort, resp_cache, resp_buf, walk_req, walk_done, wk;
  tlbr_pkg::tlbr_walk_t walk_data, tmpl;
  tlbr_pkg::tlbr_walk_t pas [3];
  logic [31:0] ad [3] = '{32'h0210_0000, 32'h0320_0000, 32'h0440_0000};
  logic [5:0] vx [3] = '{6'h3F, 6'h03, 6'h04};
  logic [6:0] p;
  int fail_count, checks, seed;

  tlbr_top i_tlbr_top (.sys_clk(sys_clk), .rst(rst), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
    .mmu_enable(mmu_enable), .dacr(dacr), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_fetch(req_fetch), .req_write(req_write), .req_priv(req_priv),
    .resp_valid(resp_valid), .resp_pa(resp_pa), .resp_abort(resp_abort),
    .resp_cache(resp_cache), .resp_buf(resp_buf), .walk_req(walk_req), .walk_mva(walk_mva),
    .walk_done(walk_done), .walk_data(walk_data));
  tlbr_walker i_tlbr_walker (.sys_clk(sys_clk), .rst(rst), .walk_req(walk_req), .lat(lat),
    .tmpl(tmpl), .walk_done(walk_done), .walk_data(walk_data));

  // Free-running 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One coprocessor transfer; read data is settled one cycle after the strobe
  task automatic cp(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
                    input logic [2:0] op2, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cp_valid = 1'b1;
    cp_write = wr;
    cp_crn = crn;
    cp_crm = crm;
    cp_op2 = op2;
    cp_wdata = d;
    @(posedge sys_clk);
    #1;
    cp_valid = 1'b0;
  endtask

  // Lockdown word with the should-be-zero bits cleared
  function automatic logic [31:0] lk(input logic [5:0] b, input logic [5:0] v, input logic pr);
    return {b, v, 19'h0, pr};
  endfunction

  // Physical address for a translation of the given size
  function automatic logic [31:0] epa(input tlbr_pkg::tlbr_walk_t t, input logic [31:0] va);
    case (t.size)
      tlbr_pkg::SZ_SECT: return {t.pa[21:10], va[19:0]};
      tlbr_pkg::SZ_LARGE: return {t.pa[21:6], va[15:0]};
      tlbr_pkg::SZ_SMALL: return {t.pa[21:2], va[11:0]};
      default: return {t.pa, va[9:0]};
    endcase
  endfunction

  // Core request held until taken; reports whether a table walk was needed
  task automatic req(input logic [31:0] ra, input logic f, output logic walked);
    int n;
    walked = 1'b0;
    n = 0;
    @(posedge sys_clk);
    #1;
    while (!req_ready && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    req_valid = 1'b1;
    req_addr = ra;
    req_fetch = f;
    req_write = 1'b0;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    while (!resp_valid && n < 80) begin
      walked = walked | walk_req;
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 80 || !resp_valid) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic rsp(input logic [31:0] pa, input logic [2:0] fl);
    chk(resp_pa, pa);
    chk({29'h0, resp_abort, resp_cache, resp_buf}, {29'h0, fl});
  endtask

  function automatic tlbr_pkg::tlbr_walk_t mk(input tlbr_pkg::tlbr_size_t s,
                                               input logic [3:0] d, input logic [7:0] ap);
    return '{size: s, dom: d, ap: ap, c: 1'b1, b: 1'b1, pa: 22'($random(seed))};
  endfunction

  // Main sequence
  initial begin
    seed = 32'hA7C3;
    {cp_valid, cp_write, mmu_enable, req_valid, req_fetch, req_write} = '0;
    {cp_crn, cp_crm, cp_op2, cp_wdata, req_addr, lat} = '0;
    dacr = 32'hFFFF_FFFF;
    req_priv = 1'b1;
    tmpl = '0;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cp(1'b0, 4'hA, 4'h0, 3'h0, 32'h0);
    chk(cp_rdata, 32'h0);
    cp(1'b0, 4'hA, 4'h0, 3'h1, 32'h0);
    chk(cp_rdata, 32'h0);
    cp(1'b0, 4'hD, 4'h0, 3'h0, 32'h0);
    chk(cp_rdata, 32'h0);
    // Lock three low entries, start the victim near the top so it wraps
    mmu_enable = 1'b1;
    cp(1'b1, 4'hA, 4'h0, 3'h1, lk(6'h03, 6'h3E, 1'b1));
    cp(1'b0, 4'hA, 4'h0, 3'h1, 32'h0);
    chk(cp_rdata, lk(6'h03, 6'h3E, 1'b1));
    cp(1'b0, 4'hA, 4'h0, 3'h0, 32'h0);
    chk(cp_rdata, 32'h0);
    for (int i = 0; i < 3; i++) begin
      tmpl = mk(tlbr_pkg::SZ_SECT, 4'h0, 8'hFF);
      pas[i] = tmpl;
      lat = 4'(i * 3);
      if (i == 2) cp(1'b1, 4'hA, 4'h0, 3'h1, lk(6'h03, 6'h03, 1'b0));
      req(ad[i], 1'b1, wk);
      chk({31'h0, wk}, 32'h1);
      rsp(epa(tmpl, ad[i]), 3'b011);
      cp(1'b0, 4'hA, 4'h0, 3'h1, 32'h0);
      chk(cp_rdata, lk(6'h03, vx[i], i != 2));
    end
    req(ad[0], 1'b1, wk);
    chk({31'h0, wk}, 32'h0);
    rsp(epa(pas[0], ad[0]), 3'b011);
    cp(1'b0, 4'hA, 4'h0, 3'h1, 32'h0);
    chk(cp_rdata, lk(6'h03, 6'h04, 1'b0));
    cp(1'b0, 4'hB, 4'h0, 3'h0, 32'h0);
    chk(cp_rdata, 32'h0);
    // Invalidate-all spares preserved entries; single invalidate does not
    cp(1'b1, 4'h8, 4'h5, 3'h0, 32'h0);
    req(ad[0], 1'b1, wk);
    chk({31'h0, wk}, 32'h0);
    req(ad[2], 1'b1, wk);
    chk({31'h0, wk}, 32'h1);
    cp(1'b1, 4'h8, 4'h5, 3'h1, ad[0]);
    req(ad[0], 1'b1, wk);
    chk({31'h0, wk}, 32'h1);
    req(ad[1], 1'b0, wk);
    chk({31'h0, wk}, 32'h1);
    // Domain 1 in abort mode, then manager, then client on quartered small pages
    tmpl = mk(tlbr_pkg::SZ_SECT, 4'h1, 8'hFF);
    dacr = 32'hFFFF_FFF3;
    req(32'h0800_0000, 1'b0, wk);
    rsp(32'h0, 3'b100);
    dacr = 32'hFFFF_FFFF;
    req(32'h0800_0000, 1'b0, wk);
    rsp(epa(tmpl, 32'h0800_0000), 3'b011);
    tmpl = mk(tlbr_pkg::SZ_SMALL, 4'h1, 8'hFC);
    dacr = 32'hFFFF_FFF7;
    req(32'h0900_0000, 1'b0, wk);
    rsp(32'h0, 3'b100);
    req(32'h0900_0400, 1'b0, wk);
    rsp(epa(tmpl, 32'h0900_0400), 3'b011);
    // Large page quarters, then a kernel-only tiny page seen by user and kernel
    tmpl = mk(tlbr_pkg::SZ_LARGE, 4'h1, 8'hF3);
    req(32'h0A00_4000, 1'b0, wk);
    rsp(32'h0, 3'b100);
    req(32'h0A00_8000, 1'b0, wk);
    rsp(epa(tmpl, 32'h0A00_8000), 3'b011);
    tmpl = mk(tlbr_pkg::SZ_TINY, 4'h1, 8'h01);
    req_priv = 1'b0;
    req(32'h0B00_0000, 1'b0, wk);
    rsp(32'h0, 3'b100);
    req_priv = 1'b1;
    req(32'h0B00_0000, 1'b0, wk);
    rsp(epa(tmpl, 32'h0B00_0000), 3'b011);
    // Invalidate both, data only, then a single data entry: each forces a new walk
    cp(1'b1, 4'h8, 4'h7, 3'h0, 32'h0);
    req(32'h0B00_0000, 1'b0, wk);
    chk({31'h0, wk}, 32'h1);
    cp(1'b1, 4'h8, 4'h6, 3'h0, 32'h0);
    req(32'h0B00_0000, 1'b0, wk);
    chk({31'h0, wk}, 32'h1);
    cp(1'b1, 4'h8, 4'h6, 3'h1, 32'h0B00_0000);
    req(32'h0B00_0000, 1'b0, wk);
    chk({31'h0, wk}, 32'h1);
    // Translation off: flat map after process remap
    mmu_enable = 1'b0;
    cp(1'b1, 4'hD, 4'h0, 3'h0, {7'h05, 25'h0});
    cp(1'b1, 4'hD, 4'h0, 3'h0, {7'h09, 25'h0});
    for (int j = 0; j < 3; j++) begin
      req(32'h0000_0100, 1'b1, wk);
      rsp({(j < 2) ? 7'h05 : 7'h09, 25'h100}, 3'b000);
    end
    // Random identifiers and addresses on both sides of the remapped window
    repeat (16) begin
      p = 7'($random(seed));
      a = $random(seed);
      if (a[0]) a[31:25] = 7'h00;
      cp(1'b1, 4'hD, 4'h0, 3'h0, {p, 25'h0});
      cp(1'b0, 4'hD, 4'h0, 3'h0, 32'h0);
      chk(cp_rdata, {p, 25'h0});
      req(a, 1'b0, wk);
      chk(resp_pa, (a[31:25] == 7'h00) ? {p, a[24:0]} : a);
    end
    end_sim();
  end
endmodule // tlbr_top_tb
